// ### rtl/mpb_pkg.sv
// constants, types and timing for the host-side parallel bus controller
// assumes a single 10 MHz clock; every count here is in cycles of it
package mpb_pkg;

  // ****************************************
  // software register map (word index)
  // ****************************************
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_CMD = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_RDATA = 4'h5;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CFG_DIRSTB = 0;
  localparam int CFG_NONMUX = 1;
  localparam int CFG_PAGE = 2;
  localparam int CFG_BURST = 3;
  localparam int CFG_USE_ALE = 4;
  localparam int CFG_SINGLE_RD = 5;
  localparam int CFG_A16 = 6;
  localparam int CFG_W = 7;
  localparam logic [6:0] CFG_RESET = 7'h10;
  localparam int CMD_RD = 0;
  localparam int CMD_WR = 1;
  localparam int CMD_FETCH = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_HIT = 1;
  localparam int ADDR_W = 17;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // ****************************************
  // bus phase timing
  // ****************************************
  localparam int CLK_MHZ = 10;
  localparam int T_ADDR_NS = 100;
  localparam int T_ALE_NS = 100;
  localparam int T_STRB_NS = 300;
  localparam int T_HOLD_NS = 100;

  function automatic logic [3:0] cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return c[3:0];
  endfunction

  localparam logic [3:0] N_ADDR = cyc_min(T_ADDR_NS);
  localparam logic [3:0] N_ALE = cyc_min(T_ALE_NS);
  localparam logic [3:0] N_STRB = cyc_min(T_STRB_NS);
  localparam logic [3:0] N_HOLD = cyc_min(T_HOLD_NS);

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_LATCH = 3'b011,
    ST_STRB = 3'b010,
    ST_HOLD = 3'b110
  } mpb_state_e;

  typedef enum logic [1:0] {
    ACC_RD = 2'b00,
    ACC_WR = 2'b01,
    ACC_FETCH = 2'b10
  } mpb_acc_e;

endpackage

// ### rtl/mpb_strobe_gen.sv
// control pin encoding for the three strobe styles
// assumes the caller registers the outputs before they reach the pins
`timescale 1ns/1ps
module mpb_strobe_gen (
  // style
  input wire logic dir_stb,
  input wire logic single_rd,
  // access
  input wire logic active,
  input wire mpb_pkg::mpb_acc_e kind,
  // pin levels
  output logic ctrl0,
  output logic ctrl1,
  output logic ctrl2
);

  logic is_wr;
  logic is_rd;
  logic is_fetch;

  assign is_wr = (kind == mpb_pkg::ACC_WR);
  assign is_rd = (kind == mpb_pkg::ACC_RD);
  assign is_fetch = (kind == mpb_pkg::ACC_FETCH);

  always_comb begin
    if (dir_stb) begin
      // direction high means read; strobe is active high; third pin left idle
      ctrl0 = !is_wr;
      ctrl1 = active;
      ctrl2 = 1'b1;
    end else if (single_rd) begin
      // reads and fetches share the one read pin
      ctrl0 = !(active && is_wr);
      ctrl1 = !(active && (is_rd || is_fetch));
      ctrl2 = 1'b1;
    end else begin
      ctrl0 = !(active && is_wr);
      ctrl1 = !(active && is_rd);
      ctrl2 = !(active && is_fetch);
    end
  end

endmodule

// ### rtl/mpb_pin_mux.sv
// address and data placement on the pins for each multiplexing mode
// assumes the caller registers the outputs before they reach the pins
`timescale 1ns/1ps
module mpb_pin_mux (
  // mode
  input wire logic nonmux,
  input wire logic burst,
  input wire logic page,
  input wire logic a16_en,
  // cycle
  input wire logic [16:0] addr,
  input wire logic addr_phase,
  input wire logic drive_data,
  input wire logic [7:0] wdata,
  // pins
  output logic [7:0] ad_o,
  output logic [7:0] ad_oe,
  output logic [7:0] hi_o,
  output logic [7:0] lo_o,
  output logic [7:0] pa_o,
  output logic [7:0] pa_oe
);

  always_comb begin
    hi_o = addr[15:8];
    lo_o = addr[7:0];
    pa_o = 8'h00;
    pa_oe = 8'h00;
    if (nonmux) begin
      // address port carries the full low address; data moves on port A
      ad_o = addr[7:0];
      ad_oe = 8'hFF;
      pa_o = wdata;
      pa_oe = {8{drive_data}};
    end else begin
      if (!addr_phase) begin
        ad_o = wdata;
      end else if (burst) begin
        ad_o = addr[11:4];
      end else if (page) begin
        ad_o = addr[15:8];
      end else begin
        ad_o = addr[7:0];
      end
      // released while the device may answer a read
      ad_oe = {8{addr_phase || drive_data}};
      if (burst) begin
        pa_o[3:0] = addr[3:0];
        pa_oe[3:0] = 4'hF;
      end else if (a16_en) begin
        pa_o[0] = addr[16];
        pa_oe[0] = 1'b1;
      end
    end
  end

endmodule

// ### rtl/mpb_host.sv
// host controller that runs single bus cycles on the device's parallel port
// assumes software programs style bits only while the engine is idle
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module mpb_host (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // control pins
  output logic ctrl_in0,
  output logic ctrl_in1,
  output logic ctrl_in2,
  output logic addr_latch_strobe,
  // multiplexed address/data port
  input wire logic [7:0] addr_data_port_i,
  output logic [7:0] addr_data_port_o,
  output logic [7:0] addr_data_port_oe,
  // address pins
  output logic [7:0] addr_hi,
  output logic [7:0] addr_lo,
  // port A
  input wire logic [7:0] port_a_i,
  output logic [7:0] port_a_o,
  output logic [7:0] port_a_oe
);

  // ****************************************
  // software registers
  // ****************************************
  logic [6:0] cfg_q;
  logic [16:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic hit_q;
  mpb_pkg::mpb_state_e st_q;
  logic accept;
  logic busy;

  assign busy = (st_q != mpb_pkg::ST_IDLE);
  // a command while busy is dropped; the config is frozen the same way
  assign accept = sw_wr && (sw_addr == mpb_pkg::REG_CMD) && !busy &&
                  (sw_wdata[2:0] != 3'b000);

  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_q <= mpb_pkg::CFG_RESET;
      addr_q <= 17'h00000;
      wdata_q <= 8'h00;
    end else if (sw_wr && !busy) begin
      case (sw_addr)
        mpb_pkg::REG_CFG: begin
          cfg_q <= sw_wdata[mpb_pkg::CFG_W-1:0];
        end
        mpb_pkg::REG_ADDR: begin
          addr_q <= sw_wdata[mpb_pkg::ADDR_W-1:0];
        end
        mpb_pkg::REG_WDATA: begin
          wdata_q <= sw_wdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sw_rdata <= mpb_pkg::DATA_ZERO;
    end else if (sw_rd) begin
      case (sw_addr)
        mpb_pkg::REG_CFG: sw_rdata <= {25'h0, cfg_q};
        mpb_pkg::REG_ADDR: sw_rdata <= {15'h0, addr_q};
        mpb_pkg::REG_WDATA: sw_rdata <= {24'h000000, wdata_q};
        mpb_pkg::REG_STAT: sw_rdata <= {30'h0, hit_q, busy};
        mpb_pkg::REG_RDATA: sw_rdata <= {24'h000000, rdata_q};
        default: sw_rdata <= mpb_pkg::DATA_ZERO;
      endcase
    end else begin
      sw_rdata <= mpb_pkg::DATA_ZERO;
    end
  end

  // ****************************************
  // cycle engine
  // ****************************************
  logic nonmux;
  logic page;
  logic burst;
  logic [16:0] up_q;
  logic up_vld_q;
  logic same_up;
  logic skip_d;
  logic skip_q;
  logic [3:0] cnt_q;
  mpb_pkg::mpb_acc_e kind_q;
  mpb_pkg::mpb_acc_e kind_d;

  assign nonmux = cfg_q[mpb_pkg::CFG_NONMUX];
  assign page = cfg_q[mpb_pkg::CFG_PAGE] && !nonmux;
  assign burst = cfg_q[mpb_pkg::CFG_BURST] && !nonmux;
  // burst keeps bits 16..4 latched, page keeps bits 16..8
  assign same_up = burst ? (up_q[16:4] == addr_q[16:4]) : (up_q[16:8] == addr_q[16:8]);
  // the device holds its latch across a hit, so no strobe is needed
  assign skip_d = (up_vld_q && (page || burst) && same_up) ||
                  (nonmux && !cfg_q[mpb_pkg::CFG_USE_ALE]);

  always_comb begin
    if (sw_wdata[mpb_pkg::CMD_WR]) begin
      kind_d = mpb_pkg::ACC_WR;
    end else if (sw_wdata[mpb_pkg::CMD_FETCH]) begin
      kind_d = mpb_pkg::ACC_FETCH;
    end else begin
      kind_d = mpb_pkg::ACC_RD;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= mpb_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      kind_q <= mpb_pkg::ACC_RD;
      skip_q <= 1'b0;
    end else begin
      case (st_q)
        mpb_pkg::ST_IDLE: begin
          if (accept) begin
            st_q <= mpb_pkg::ST_ADDR;
            cnt_q <= mpb_pkg::N_ADDR - 4'h1;
            kind_q <= kind_d;
            skip_q <= skip_d;
          end
        end
        mpb_pkg::ST_ADDR: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (skip_q) begin
            st_q <= mpb_pkg::ST_STRB;
            cnt_q <= mpb_pkg::N_STRB - 4'h1;
          end else begin
            st_q <= mpb_pkg::ST_LATCH;
            cnt_q <= mpb_pkg::N_ALE - 4'h1;
          end
        end
        mpb_pkg::ST_LATCH: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            st_q <= mpb_pkg::ST_STRB;
            cnt_q <= mpb_pkg::N_STRB - 4'h1;
          end
        end
        mpb_pkg::ST_STRB: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            st_q <= mpb_pkg::ST_HOLD;
            cnt_q <= mpb_pkg::N_HOLD - 4'h1;
          end
        end
        mpb_pkg::ST_HOLD: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            st_q <= mpb_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= mpb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // the upper address the device now holds in its latch
  always_ff @(posedge mclk) begin
    if (reset) begin
      up_q <= 17'h00000;
      up_vld_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      if (st_q == mpb_pkg::ST_LATCH) begin
        up_q <= addr_q;
        up_vld_q <= 1'b1;
      end else if (accept) begin
        hit_q <= skip_d;
      end else if (sw_wr && !busy && (sw_addr == mpb_pkg::REG_CFG)) begin
        // a new style leaves a latch whose contents no longer match up_q
        up_vld_q <= 1'b0;
      end
    end
  end

  // read data is caught while the pins still show the strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if ((st_q == mpb_pkg::ST_HOLD) && (kind_q != mpb_pkg::ACC_WR)) begin
      rdata_q <= nonmux ? port_a_i : addr_data_port_i;
    end
  end

  // ****************************************
  // pin drive, all registered
  // ****************************************
  logic strb_act;
  logic addr_phase;
  logic drive_data;
  logic c0;
  logic c1;
  logic c2;
  logic [7:0] ad_o;
  logic [7:0] ad_oe;
  logic [7:0] hi_o;
  logic [7:0] lo_o;
  logic [7:0] pa_o;
  logic [7:0] pa_oe;
  logic strb_q;

  assign strb_act = (st_q == mpb_pkg::ST_STRB);
  assign addr_phase = (st_q == mpb_pkg::ST_ADDR) || (st_q == mpb_pkg::ST_LATCH);
  assign drive_data = (kind_q == mpb_pkg::ACC_WR) &&
                      ((st_q == mpb_pkg::ST_STRB) || (st_q == mpb_pkg::ST_HOLD));

  mpb_strobe_gen u_strb (
    .dir_stb(cfg_q[mpb_pkg::CFG_DIRSTB]),
    .single_rd(cfg_q[mpb_pkg::CFG_SINGLE_RD]),
    .active(strb_act),
    .kind(kind_q),
    .ctrl0(c0),
    .ctrl1(c1),
    .ctrl2(c2)
  );

  mpb_pin_mux u_mux (
    .nonmux(nonmux),
    .burst(burst),
    .page(page),
    .a16_en(cfg_q[mpb_pkg::CFG_A16]),
    .addr(addr_q),
    .addr_phase(addr_phase),
    .drive_data(drive_data),
    .wdata(wdata_q),
    .ad_o(ad_o),
    .ad_oe(ad_oe),
    .hi_o(hi_o),
    .lo_o(lo_o),
    .pa_o(pa_o),
    .pa_oe(pa_oe)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_in0 <= 1'b1;
      ctrl_in1 <= 1'b1;
      ctrl_in2 <= 1'b1;
      addr_latch_strobe <= 1'b0;
      strb_q <= 1'b0;
    end else begin
      ctrl_in0 <= c0;
      ctrl_in1 <= cfg_q[mpb_pkg::CFG_DIRSTB] ? (c1 && busy) : c1;
      ctrl_in2 <= c2;
      addr_latch_strobe <= (st_q == mpb_pkg::ST_ADDR) && !skip_q;
      strb_q <= strb_act;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      addr_data_port_o <= 8'h00;
      addr_data_port_oe <= 8'h00;
      addr_hi <= 8'h00;
      addr_lo <= 8'h00;
      port_a_o <= 8'h00;
      port_a_oe <= 8'h00;
    end else begin
      addr_data_port_o <= ad_o;
      addr_data_port_oe <= busy ? ad_oe : 8'h00;
      addr_hi <= hi_o;
      addr_lo <= lo_o;
      port_a_o <= pa_o;
      port_a_oe <= busy ? pa_oe : 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic ale_seen_q;

  always_ff @(posedge mclk) begin
    if (reset || accept) begin
      ale_seen_q <= 1'b0;
    end else if (addr_latch_strobe) begin
      ale_seen_q <= 1'b1;
    end
  end

  property p_ale_each_cycle;
    @(posedge mclk) disable iff (reset)
      ($rose(strb_q) && !nonmux && !page && !burst) |-> ale_seen_q;
  endproperty
  a_ale_each_cycle: assert property (p_ale_each_cycle) else $error("no latch strobe");

  property p_hit_no_ale;
    @(posedge mclk) disable iff (reset)
      ((st_q == mpb_pkg::ST_ADDR) && skip_q && (page || burst)) |=> !addr_latch_strobe;
  endproperty
  a_hit_no_ale: assert property (p_hit_no_ale) else $error("latch strobe on page hit");

  property p_burst_low_bits;
    @(posedge mclk) disable iff (reset)
      ($rose(strb_q) && burst) |-> (port_a_o[3:0] == addr_q[3:0]) && (port_a_oe[3:0] == 4'hF);
  endproperty
  a_burst_low_bits: assert property (p_burst_low_bits) else $error("burst low bits");

  property p_nonmux_no_ale;
    @(posedge mclk) disable iff (reset)
      (busy && nonmux && !cfg_q[mpb_pkg::CFG_USE_ALE]) |=> !addr_latch_strobe;
  endproperty
  a_nonmux_no_ale: assert property (p_nonmux_no_ale) else $error("unwanted latch strobe");

  property p_read_release;
    @(posedge mclk) disable iff (reset)
      (strb_q && !nonmux && (kind_q != mpb_pkg::ACC_WR)) |-> (addr_data_port_oe == 8'h00);
  endproperty
  a_read_release: assert property (p_read_release) else $error("bus driven in read");

  property p_cycle_ends;
    @(posedge mclk) disable iff (reset)
      accept |-> ##[4:20] (st_q == mpb_pkg::ST_IDLE);
  endproperty
  a_cycle_ends: assert property (p_cycle_ends) else $error("cycle did not end");

endmodule

// ### test/mpb_dev_model.sv
// behavioural model of the device's host bus port: latch, decode, memory
// assumes the bench resolves shared wires and sets the style only while idle
`timescale 1ns/1ps
module mpb_dev_model (
  // static style, never changed mid-cycle
  input wire logic dir_stb,
  input wire logic nonmux,
  input wire logic single_rd,
  input wire logic page,
  input wire logic burst,
  input wire logic a16_en,
  // control pins
  input wire logic ctrl0,
  input wire logic ctrl1,
  input wire logic ctrl2,
  input wire logic ale,
  // resolved wires
  input wire logic [7:0] ad_pin,
  input wire logic [7:0] hi_pin,
  input wire logic [7:0] lo_pin,
  input wire logic [7:0] pa_pin,
  // drivers
  output logic [7:0] ad_drv,
  output logic [7:0] ad_den,
  output logic [7:0] pa_drv,
  output logic [7:0] pa_den
);
  // ****************************************
  // latch, decode and storage
  // ****************************************
  logic [7:0] mem [0:511];
  logic [7:0] lat;
  logic [16:0] a;
  logic rd;
  logic wr;
  logic own;
  logic [8:0] idx;

  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
  end

  // transparent while the strobe is high, so a late address still lands
  always @(ale or ad_pin) begin
    if (ale) begin
      lat = ad_pin;
    end
  end

  always_comb begin
    a = {1'b0, hi_pin, lat};
    if (nonmux) begin
      a[7:0] = ad_pin;
    end
    if (page) begin
      a = {1'b0, lat, lo_pin};
    end
    if (burst) begin
      a = {1'b0, hi_pin[7:4], lat, pa_pin[3:0]};
    end
    if (a16_en && !burst) begin
      a[16] = pa_pin[0];
    end
  end

  // spare third pin is ignored outside the dual-read style
  assign rd = dir_stb ? (ctrl0 && ctrl1) :
              (!ctrl1 || (!single_rd && !ctrl2));
  assign wr = dir_stb ? (!ctrl0 && ctrl1) : !ctrl0;
  assign own = a[15];
  // byte-high enable does not exist on an 8-bit bus; A16 and A7..A0 pick the byte
  assign idx = {a[16], a[7:0]};
  assign ad_drv = mem[idx];
  assign pa_drv = mem[idx];
  assign ad_den = {8{rd && own && !nonmux}};
  assign pa_den = {8{rd && own && nonmux}};

  always @(negedge wr) begin
    if (own) begin
      mem[idx] = nonmux ? pa_pin : ad_pin;
    end
  end
endmodule

// ### test/mpb_host_tb_top.sv
// self-checking bench for the host bus controller against a device model
// assumes the package constants and the hand-over cycle timing
`timescale 1ns/1ps
module mpb_host_tb_top;
  // ****************************************
  // wiring, clock and monitors
  // ****************************************
  logic mclk;
  logic reset = 1'b1;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic [31:0] sw_rdata;
  logic ctrl_in0, ctrl_in1, ctrl_in2, ale;
  logic [7:0] ad_o, ad_oe, ad_w, hi, lo, pa_o, pa_oe, pa_w, ad_dv, ad_de, pa_dv, pa_de;
  logic [7:0] flt_q = 8'h5A;
  logic [6:0] cfg_m = mpb_pkg::CFG_RESET;
  logic [31:0] st;
  logic [7:0] r;
  int fail_count = 0;
  int tests_run = 0;
  int ale_cnt = 0;
  int c2_cnt = 0;
  int cyc = 0;
  int n0;

  // released lines toggle so a stale value never passes for data
  assign ad_w = (ad_de & ad_dv) | (~ad_de & ad_oe & ad_o) | (~ad_de & ~ad_oe & flt_q);
  assign pa_w = (pa_de & pa_dv) | (~pa_de & pa_oe & pa_o) | (~pa_de & ~pa_oe & flt_q);

  mpb_host dut (.mclk(mclk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ctrl_in0(ctrl_in0),
    .ctrl_in1(ctrl_in1), .ctrl_in2(ctrl_in2), .addr_latch_strobe(ale),
    .addr_data_port_i(ad_w), .addr_data_port_o(ad_o), .addr_data_port_oe(ad_oe),
    .addr_hi(hi), .addr_lo(lo), .port_a_i(pa_w), .port_a_o(pa_o), .port_a_oe(pa_oe));

  mpb_dev_model dev (.dir_stb(cfg_m[0]), .nonmux(cfg_m[1]), .single_rd(cfg_m[5]),
    .page(cfg_m[2]), .burst(cfg_m[3]), .a16_en(cfg_m[6]), .ctrl0(ctrl_in0),
    .ctrl1(ctrl_in1), .ctrl2(ctrl_in2), .ale(ale), .ad_pin(ad_w), .hi_pin(hi),
    .lo_pin(lo), .pa_pin(pa_w), .ad_drv(ad_dv), .ad_den(ad_de), .pa_drv(pa_dv),
    .pa_den(pa_de));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    flt_q <= ~flt_q;
    cyc++;
    if (ale === 1'b1) begin
      ale_cnt++;
    end
    if (ctrl_in2 === 1'b0) begin
      c2_cnt++;
    end
    if (cyc == 5000) begin
      fail_count++;
      $display("BAD run length expected below 5000 seen 5000");
      results();
    end
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic sw_w(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_r(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  task automatic set_cfg(input logic [6:0] c);
    sw_w(mpb_pkg::REG_CFG, {25'h0, c});
    cfg_m <= c;
    n0 = ale_cnt;
  endtask

  task automatic bus_op(input logic [2:0] cmd, input logic [16:0] a, input logic [7:0] d);
    int n;
    logic [31:0] rw;
    sw_w(mpb_pkg::REG_ADDR, {15'h0, a});
    sw_w(mpb_pkg::REG_WDATA, {24'h0, d});
    sw_w(mpb_pkg::REG_CMD, {29'h0, cmd});
    n = 0;
    do begin
      sw_r(mpb_pkg::REG_STAT, st);
      n++;
    end while (st[0] !== 1'b0 && n < 30);
    if (n >= 30) begin
      fail_count++;
      $display("BAD busy expected 0 seen 1");
    end
    sw_r(mpb_pkg::REG_RDATA, rw);
    r = rw[7:0];
  endtask

  function automatic logic [31:0] ini(input logic [16:0] a);
    return {24'h0, a[7:0] ^ 8'h5A};
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] v;
    sw_r(mpb_pkg::REG_CFG, v);
    chk("cfg reset", {25'h0, mpb_pkg::CFG_RESET}, v);
    sw_r(4'hF, v);
    chk("unmapped read", 32'h0, v);
    chk("idle enables", 32'h0, {16'h0, ad_oe, pa_oe});
    chk("idle ctrl", 32'h7, {29'h0, ctrl_in0, ctrl_in1, ctrl_in2});
  endtask

  task automatic t_sep;
    int c0;
    set_cfg(7'h10);
    bus_op(3'b010, 17'h08012, 8'hC3);
    bus_op(3'b001, 17'h08012, 8'h00);
    chk("sep read", 32'hC3, {24'h0, r});
    c0 = c2_cnt;
    bus_op(3'b100, 17'h08013, 8'h00);
    chk("sep fetch", ini(17'h08013), {24'h0, r});
    chk("fetch strobe cycles", 32'd3, 32'(c2_cnt - c0));
    chk("latch per cycle", 32'd3, 32'(ale_cnt - n0));
  endtask

  task automatic t_single;
    int c0;
    set_cfg(7'h30);
    c0 = c2_cnt;
    bus_op(3'b100, 17'h08021, 8'h00);
    chk("single fetch", ini(17'h08021), {24'h0, r});
    chk("spare pin idle", 32'd0, 32'(c2_cnt - c0));
  endtask

  task automatic t_dir;
    set_cfg(7'h11);
    bus_op(3'b010, 17'h08040, 8'h6E);
    bus_op(3'b001, 17'h08040, 8'h00);
    chk("dir read", 32'h6E, {24'h0, r});
  endtask

  task automatic t_hits(input logic [6:0] c, input logic [16:0] a0, input logic [16:0] a1);
    set_cfg(c);
    bus_op(3'b001, a0, 8'h00);
    chk("hit first", ini(a0), {24'h0, r});
    bus_op(3'b001, a1, 8'h00);
    chk("hit data", ini(a1), {24'h0, r});
    chk("hit flag", 32'd1, {31'h0, st[mpb_pkg::STAT_HIT]});
    bus_op(3'b010, a1 + 17'd1, 8'h3D);
    bus_op(3'b001, a1 + 17'd1, 8'h00);
    chk("hit write", 32'h3D, {24'h0, r});
    chk("one latch", 32'd1, 32'(ale_cnt - n0));
  endtask

  task automatic t_nonmux;
    set_cfg(7'h02);
    bus_op(3'b010, 17'h08066, 8'h99);
    bus_op(3'b001, 17'h08066, 8'h00);
    chk("nonmux read", 32'h99, {24'h0, r});
    chk("no latch", 32'd0, 32'(ale_cnt - n0));
  endtask

  task automatic t_a16;
    set_cfg(7'h50);
    bus_op(3'b010, 17'h18070, 8'h77);
    bus_op(3'b001, 17'h08070, 8'h00);
    chk("a16 low half", ini(17'h08070), {24'h0, r});
    bus_op(3'b001, 17'h18070, 8'h00);
    chk("a16 high half", 32'h77, {24'h0, r});
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_sep();
    t_single();
    t_dir();
    t_hits(7'h14, 17'h08150, 17'h08155);
    t_hits(7'h18, 17'h08230, 17'h08237);
    t_nonmux();
    t_a16();
    results();
  end
endmodule
